//--- rtl/cap_defs.svh
`ifndef CAP_DEFS_SVH
`define CAP_DEFS_SVH
`define CAP_ADDR_W 30
`define CAP_LINE_W 28
`define CAP_DEF_W 3
`define CAP_A20_IDX 18
`define CAP_SYNC_W 31
// mask, hold and snoop strobe come out of reset high, inward address lines low
`define CAP_SYNC_RST 31'h70000000
`define CAP_EXT_SNOOP_STROBE_N_FIRST 2'h2
`define CAP_DEF_WB_WRITE 3'h7
`endif

//--- rtl/cap_pkg.sv
package cap_pkg;
   typedef enum logic [2:0] {CAP_IDLE, CAP_ADDR, CAP_DATA, CAP_WB_ADDR, CAP_WB_DATA} cap_state_e;
endpackage

//--- rtl/cap_sync.sv
`timescale 1ns/1ps
module cap_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [WIDTH-1:0] i_d,
   output logic [WIDTH-1:0] o_q
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] q_reg;

   // reset to each pin's RST_VAL; idle for all but hold, which resets asserted until the pin is seen
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         meta_reg <= RST_VAL;
         q_reg <= RST_VAL;
      end
      else
      begin
         meta_reg <= i_d;
         q_reg <= meta_reg;
      end
   end

   assign o_q = q_reg;
endmodule

//--- rtl/cap_top.sv
`timescale 1ns/1ps
`include "cap_defs.svh"
module cap_top
   import cap_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_addr20_mask_n,
   input wire logic i_addr_hold_req,
   input wire logic i_ext_snoop_strobe_n,
   input wire logic [`CAP_LINE_W-1:0] i_phys_addr_bus,
   input wire logic i_bus_hold,
   input wire logic i_cyc_req,
   input wire logic [`CAP_ADDR_W-1:0] i_cyc_addr,
   input wire logic [`CAP_DEF_W-1:0] i_cyc_def,
   input wire logic i_cyc_mem,
   input wire logic i_cyc_done,
   input wire logic [`CAP_ADDR_W-1:0] i_lookup_addr,
   input wire logic i_snoop_done,
   input wire logic i_snoop_hit_mod,
   output logic [`CAP_ADDR_W-1:0] o_phys_addr_bus,
   output logic o_phys_addr_bus_oe,
   output logic o_addr_strobe_n,
   output logic o_addr_strobe_oe,
   output logic [`CAP_DEF_W-1:0] o_cyc_def,
   output logic o_cyc_accept,
   output logic o_data_phase,
   output logic [`CAP_ADDR_W-1:0] o_lookup_addr,
   output logic o_snoop_req,
   output logic [`CAP_LINE_W-1:0] o_snoop_addr,
   output logic o_snoop_hit_modified_n
);
   typedef struct packed {
      cap_state_e st;
      logic [`CAP_ADDR_W-1:0] addr;
      logic [`CAP_DEF_W-1:0] def;
      logic strobe_n;
      logic addr_oe;
      logic strobe_oe;
      logic accept;
      logic data_act;
      logic [`CAP_ADDR_W-1:0] lookup;
      logic snoop_req;
      logic snoop_busy;
      logic [`CAP_LINE_W-1:0] snoop_addr;
      logic snoop_hit_modified_n_n;
      logic wb_pend;
      logic [1:0] hold_cnt;
      logic ext_snoop_strobe_n_blk;
   } cap_regs_s;

   cap_regs_s s_reg;
   cap_regs_s s_next;
   logic [`CAP_SYNC_W-1:0] sync_q;
   logic mask_n_s;
   logic hold_s;
   logic ext_snoop_strobe_n_n_s;
   logic [`CAP_LINE_W-1:0] ain_s;
   logic start_cyc;
   logic start_wb;
   logic ext_snoop_strobe_n_ok;

   // clears bit 18 of a word address (byte address bit 20) when the mask is active
   function automatic logic [`CAP_ADDR_W-1:0] cap_mask20(
      input logic [`CAP_ADDR_W-1:0] a,
      input logic mask_n
   );
      logic [`CAP_ADDR_W-1:0] r;
      r = a;
      if (!mask_n)
      begin
         r[`CAP_A20_IDX] = 1'b0;
      end
      return r;
   endfunction

   // mask, hold, snoop strobe and address pins cross two flops; address and snoop strobe share the latency so they stay aligned
   // hold reads as asserted until the pin itself is seen, so the bus stays off after reset
   cap_sync #(
      .WIDTH(`CAP_SYNC_W),
      .RST_VAL(`CAP_SYNC_RST)
   ) u_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_d({i_addr20_mask_n, i_addr_hold_req, i_ext_snoop_strobe_n, i_phys_addr_bus}),
      .o_q(sync_q)
   );
   assign mask_n_s = sync_q[`CAP_SYNC_W-1];
   assign hold_s = sync_q[`CAP_SYNC_W-2];
   assign ext_snoop_strobe_n_n_s = sync_q[`CAP_SYNC_W-3];
   assign ain_s = sync_q[`CAP_LINE_W-1:0];

   // write-back wins over new cycles; new cycles wait out any address hold
   assign start_wb = (s_reg.st == CAP_IDLE) && s_reg.wb_pend && !i_bus_hold;
   assign start_cyc = (s_reg.st == CAP_IDLE) && !s_reg.wb_pend && i_cyc_req
      && !hold_s && !i_bus_hold;
   // snoop strobe seen only from the third clock of hold, not while hit pending
   assign ext_snoop_strobe_n_ok = hold_s && (s_reg.hold_cnt == `CAP_EXT_SNOOP_STROBE_N_FIRST) && !ext_snoop_strobe_n_n_s
      && !s_reg.ext_snoop_strobe_n_blk && s_reg.snoop_hit_modified_n_n && !s_reg.snoop_busy;

   always_comb
   begin
      s_next = s_reg;
      s_next.accept = 1'b0;
      s_next.snoop_req = 1'b0;
      s_next.strobe_n = 1'b1;
      s_next.lookup = cap_mask20(i_lookup_addr, mask_n_s);
      s_next.hold_cnt = !hold_s ? 2'h0 :
         (s_reg.hold_cnt == `CAP_EXT_SNOOP_STROBE_N_FIRST) ? s_reg.hold_cnt : s_reg.hold_cnt + 2'h1;
      s_next.ext_snoop_strobe_n_blk = ext_snoop_strobe_n_ok || !s_reg.strobe_n;
      case (s_reg.st)
         CAP_IDLE:
         begin
            if (start_wb)
            begin
               s_next.st = CAP_WB_ADDR;
               s_next.addr = {s_reg.snoop_addr, 2'b00};
               s_next.def = `CAP_DEF_WB_WRITE;
               s_next.strobe_n = 1'b0;
            end
            else if (start_cyc)
            begin
               s_next.st = CAP_ADDR;
               // memory cycles only; i/o space is never wrapped
               s_next.addr = i_cyc_mem ? cap_mask20(i_cyc_addr, mask_n_s) : i_cyc_addr;
               s_next.def = i_cyc_def;
               s_next.strobe_n = 1'b0;
               s_next.accept = 1'b1;
            end
         end
         CAP_ADDR:
         begin
            s_next.st = CAP_DATA;
         end
         CAP_DATA:
         begin
            // completion is taken regardless of address hold
            if (i_cyc_done)
            begin
               s_next.st = CAP_IDLE;
            end
         end
         CAP_WB_ADDR:
         begin
            s_next.st = CAP_WB_DATA;
         end
         CAP_WB_DATA:
         begin
            if (i_cyc_done)
            begin
               s_next.st = CAP_IDLE;
               s_next.wb_pend = 1'b0;
               s_next.snoop_hit_modified_n_n = 1'b1;
            end
         end
         default:
         begin
            s_next.st = CAP_IDLE;
         end
      endcase
      s_next.data_act = (s_next.st == CAP_DATA) || (s_next.st == CAP_WB_DATA)
         || (s_next.st == CAP_ADDR) || (s_next.st == CAP_WB_ADDR);
      if (ext_snoop_strobe_n_ok)
      begin
         s_next.snoop_req = 1'b1;
         s_next.snoop_busy = 1'b1;
         s_next.snoop_addr = ain_s;
      end
      else if (i_snoop_done && s_reg.snoop_busy)
      begin
         s_next.snoop_busy = 1'b0;
         if (i_snoop_hit_mod)
         begin
            s_next.wb_pend = 1'b1;
            s_next.snoop_hit_modified_n_n = 1'b0;
         end
      end
      // the held bus floats the clock after hold is seen, except for write-back
      s_next.addr_oe = !i_bus_hold && (!hold_s || (s_next.st == CAP_WB_ADDR)
         || (s_next.st == CAP_WB_DATA));
      s_next.strobe_oe = !i_bus_hold;
   end

   // reset leaves address lines floating, so a hold during reset is already met
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         s_reg <= '{st: CAP_IDLE, addr: '0, def: '0, strobe_n: 1'b1, addr_oe: 1'b0,
            strobe_oe: 1'b1, accept: 1'b0, data_act: 1'b0, lookup: '0, snoop_req: 1'b0,
            snoop_busy: 1'b0, snoop_addr: '0, snoop_hit_modified_n_n: 1'b1, wb_pend: 1'b0, hold_cnt: 2'h0,
            ext_snoop_strobe_n_blk: 1'b0};
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign o_phys_addr_bus = s_reg.addr;
   assign o_phys_addr_bus_oe = s_reg.addr_oe;
   assign o_addr_strobe_n = s_reg.strobe_n;
   assign o_addr_strobe_oe = s_reg.strobe_oe;
   assign o_cyc_def = s_reg.def;
   assign o_cyc_accept = s_reg.accept;
   assign o_data_phase = s_reg.data_act;
   assign o_lookup_addr = s_reg.lookup;
   assign o_snoop_req = s_reg.snoop_req;
   assign o_snoop_addr = s_reg.snoop_addr;
   assign o_snoop_hit_modified_n = s_reg.snoop_hit_modified_n_n;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_hold_float: assert property (hold_s && !s_reg.wb_pend |=> !o_phys_addr_bus_oe)
      else $error("address bus driven during address hold");
   a_no_new_cycle: assert property (hold_s && !s_reg.wb_pend |=> o_addr_strobe_n)
      else $error("new cycle started during address hold");
   a_strobe_float: assert property (i_bus_hold |=> !o_addr_strobe_oe
      && !o_phys_addr_bus_oe)
      else $error("strobe driven during bus hold");
   a_strobe_with_addr: assert property (!o_addr_strobe_n |-> o_phys_addr_bus_oe
      && o_addr_strobe_oe && o_data_phase)
      else $error("strobe without driven address");
   a_a20_cycle: assert property (start_cyc && i_cyc_mem && !mask_n_s
      |=> !o_addr_strobe_n && !o_phys_addr_bus[`CAP_A20_IDX])
      else $error("bit 20 not masked on memory cycle");
   a_a20_lookup: assert property (!mask_n_s |=> !o_lookup_addr[`CAP_A20_IDX])
      else $error("bit 20 not masked on lookup");
   a_snoop_window: assert property (o_snoop_req |-> $past(hold_s, 3)
      && !$past(o_snoop_req))
      else $error("snoop strobe taken too early");
   a_wb_drive: assert property (start_wb |=> !o_addr_strobe_n && o_phys_addr_bus_oe
      && !o_snoop_hit_modified_n ##1 o_addr_strobe_n)
      else $error("write-back not driven despite hold");
   a_data_keeps: assert property ((s_reg.st == CAP_DATA) && hold_s && !i_cyc_done
      |=> o_data_phase)
      else $error("data phase dropped during address hold");
endmodule

//--- sim/cap_chipset_model.sv
`timescale 1ns/1ps
`include "cap_defs.svh"
module cap_chipset_model (
   input wire logic i_clk,
   input wire logic i_hold,
   input wire logic [`CAP_LINE_W-1:0] i_line,
   output logic o_addr_hold_req,
   output logic o_ext_snoop_strobe_n,
   output logic [`CAP_LINE_W-1:0] o_phys_addr_bus
);
   logic [2:0] cnt;
   initial
   begin
      cnt = 3'h0;
      o_addr_hold_req = 1'b0;
      o_ext_snoop_strobe_n = 1'b1;
      o_phys_addr_bus = '0;
   end
   // snoop strobe on the third clock after hold rises; hold is kept far longer than two clocks
   always @(posedge i_clk)
   begin
      o_addr_hold_req <= i_hold;
      cnt <= !i_hold ? 3'h0 : (cnt == 3'h7 ? cnt : cnt + 3'h1);
      o_ext_snoop_strobe_n <= !(i_hold && cnt == 3'h3);
      // outside the strobe the lines wander so a stale value is never mistaken for a hit
      o_phys_addr_bus <= (i_hold && cnt == 3'h3) ? i_line : ~o_phys_addr_bus;
   end
endmodule

//--- sim/cap_top_tb.sv
`timescale 1ns/1ps
`include "cap_defs.svh"
module cap_top_tb;
   logic clk, rst, mask_n, ph, bh, req, mem, done, sdone, shit, seen;
   logic hreq, sstb_n, aoe, stb_n, soe, acc, dph, sreq, snoop_hit_modified_n_n;
   logic [`CAP_ADDR_W-1:0] a_in, lk_in, a_o, lk_o;
   logic [`CAP_LINE_W-1:0] line, bus, sa;
   logic [`CAP_DEF_W-1:0] def_o, def_in;
   int miscompares, checks_done, n;
   cap_chipset_model u_chip (.i_clk(clk), .i_hold(ph), .i_line(line), .o_addr_hold_req(hreq),
      .o_ext_snoop_strobe_n(sstb_n), .o_phys_addr_bus(bus));
   cap_top dut (.i_clk(clk), .i_rst(rst), .i_addr20_mask_n(mask_n), .i_addr_hold_req(hreq),
      .i_ext_snoop_strobe_n(sstb_n), .i_phys_addr_bus(bus), .i_bus_hold(bh), .i_cyc_req(req),
      .i_cyc_addr(a_in), .i_cyc_def(def_in), .i_cyc_mem(mem), .i_cyc_done(done),
      .i_lookup_addr(lk_in), .i_snoop_done(sdone), .i_snoop_hit_mod(shit), .o_phys_addr_bus(a_o),
      .o_phys_addr_bus_oe(aoe), .o_addr_strobe_n(stb_n), .o_addr_strobe_oe(soe),
      .o_cyc_def(def_o), .o_cyc_accept(acc), .o_data_phase(dph), .o_lookup_addr(lk_o),
      .o_snoop_req(sreq), .o_snoop_addr(sa), .o_snoop_hit_modified_n(snoop_hit_modified_n_n));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic cmp(input string w, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         miscompares++;
         $display("BAD %s exp %h got %h", w, e, g);
      end
   endtask
   task automatic final_report();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   task automatic chk_to(input int b);
      if (n >= b)
      begin
         miscompares++;
         final_report();
      end
   endtask
   task automatic wait_acc();
      for (n = 0; n < 10 && acc !== 1'b1; n++) step();
      chk_to(10);
   endtask
   task automatic pulse_done();
      @(posedge clk) done <= 1'b1;
      @(posedge clk) done <= 1'b0;
   endtask
   // done is held off the strobe cycle, where the data side ignores it
   task automatic finish_cycle();
      @(posedge clk) req <= 1'b0;
      pulse_done();
   endtask
   task automatic core_cycle(input logic m, input logic msk, input logic [29:0] a);
      logic [29:0] e;
      e = a;
      if (!msk)
         e[`CAP_A20_IDX] = 1'b0;
      @(posedge clk);
      mask_n <= msk;
      lk_in <= a;
      repeat (3) @(posedge clk);
      req <= 1'b1;
      mem <= m;
      a_in <= a;
      def_in <= {m, msk, 1'b1};
      wait_acc();
      cmp("strobe", 0, stb_n);
      cmp("def", {m, msk, 1'b1}, def_o);
      cmp("addr", m ? e : a, a_o);
      cmp("lookup", e, lk_o);
      finish_cycle();
      step();
      cmp("strobe end", 1, stb_n);
   endtask
   task automatic hold_snoop(input logic hit, input logic [27:0] l);
      @(posedge clk);
      req <= 1'b1;
      line <= l;
      wait_acc();
      @(posedge clk) ph <= 1'b1;
      for (n = 0; n < 4 && aoe !== 1'b0; n++) step();
      cmp("addr oe hold", 0, aoe);
      for (n = 0; n < 10 && sreq !== 1'b1; n++) step();
      chk_to(10);
      cmp("snoop addr", l, sa);
      @(posedge clk);
      sdone <= 1'b1;
      shit <= hit;
      @(posedge clk);
      sdone <= 1'b0;
      shit <= 1'b0;
      #1;
      cmp("hit flag", !hit, snoop_hit_modified_n_n);
      cmp("data phase hold", 1, dph);
      pulse_done();
      if (hit)
      begin
         for (n = 0; n < 10 && stb_n !== 1'b0; n++) step();
         chk_to(10);
         cmp("wb addr", {l, 2'h0}, a_o);
         cmp("wb def", `CAP_DEF_WB_WRITE, def_o);
         cmp("wb oe", 1, aoe);
         pulse_done();
         step();
         step();
         cmp("hit clear", 1, snoop_hit_modified_n_n);
      end
      seen = 1'b0;
      repeat (6)
      begin
         step();
         seen = seen | !stb_n;
      end
      cmp("start in hold", 0, seen);
      cmp("data phase", 0, dph);
      @(posedge clk) ph <= 1'b0;
      wait_acc();
      finish_cycle();
   endtask
   task automatic bus_hold_float();
      @(posedge clk) bh <= 1'b1;
      step();
      cmp("strobe oe", 0, soe);
      cmp("addr oe bh", 0, aoe);
      @(posedge clk) bh <= 1'b0;
      step();
      cmp("strobe oe back", 1, soe);
   endtask
   initial
   begin
      rst = 1'b1;
      mask_n = 1'b1;
      ph = 1'b1;
      {bh, req, mem, done, sdone, shit} = 6'h00;
      def_in = 3'h2;
      a_in = '0;
      lk_in = '0;
      line = '0;
      miscompares = 0;
      checks_done = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      seen = 1'b0;
      repeat (5)
      begin
         step();
         seen = seen | aoe;
      end
      cmp("addr oe reset hold", 0, seen);
      @(posedge clk) ph <= 1'b0;
      repeat (5) step();
      cmp("addr oe idle", 1, aoe);
      core_cycle(1'b1, 1'b0, 30'h3FF40123);
      core_cycle(1'b1, 1'b1, 30'h3FF40123);
      core_cycle(1'b0, 1'b0, 30'h00040456);
      hold_snoop(1'b0, 28'hABCDE12);
      hold_snoop(1'b1, 28'h5A5A5A5);
      bus_hold_float();
      final_report();
   end
endmodule
